// ---- hdl/rbwe_pkg.sv ----
// Constants shared by the registered bus width exchanger
package rbwe_pkg;

   // -----------------------------------------------------------------
   // Port widths
   // -----------------------------------------------------------------
   localparam int NARROW_W = 12;
   localparam int HALF_W = 12;
   localparam int WIDE_W = 24;

   // -----------------------------------------------------------------
   // Register bus
   // -----------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [APB_AW-1:0] STATUS_OFS = 8'h04;
   localparam logic [APB_AW-1:0] NARROW_CAP_OFS = 8'h08;
   localparam logic [APB_AW-1:0] WIDE_CAP_OFS = 8'h0C;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_HIZ_BIT = 0;
   localparam int ST_NARROW_OE_BIT = 0;
   localparam int ST_WIDE_OE_BIT = 1;
   localparam int ST_SEL_BIT = 2;
   localparam int ST_HIZ_BIT = 3;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic OE_RST = 1'b1;
   localparam logic SEL_RST = 1'b0;
   localparam logic HIZ_RST = 1'b0;
   localparam logic [HALF_W-1:0] DATA_RST = 12'h000;
   localparam logic [APB_DW-1:0] RDATA_RST = 32'h00000000;

endpackage : rbwe_pkg

// ---- hdl/rbwe_top.sv ----
// Registered 12-bit to 24-bit bus width exchanger with an APB view
//
// Overview of operation
// - The narrow port is 12 bits, the wide port 24 bits in two 12-bit halves.
// - Each storage register loads only at a rising edge while its enable is low.
// - The narrow output shows the first half when select is high, else the second.
// - Wide-to-narrow data holds while the selected half's wide enable is high.
// - Narrow data reaches the first wide half via two stages with both enables low.
// - Narrow data enters the second wide half in one edge when its enable is low.
// - With both narrow enables high both wide halves keep their stored value.
// - Sequenced enables put two successive narrow words out as one wide word.
// - Each port has a registered active-low output enable sampled at the edge.
// - Drive state is defined only from the first rising edge (here: reset).
//
// The APB register port and the register offsets were chosen for this implementation.
module rbwe_top (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Narrow port
   input wire logic [rbwe_pkg::NARROW_W-1:0] A_I,
   output logic [rbwe_pkg::NARROW_W-1:0] A_O,
   output logic A_OE_N_O,
   // Wide port, first half
   input wire logic [rbwe_pkg::HALF_W-1:0] WFH_I,
   output logic [rbwe_pkg::HALF_W-1:0] WFH_O,
   // Wide port, second half
   input wire logic [rbwe_pkg::HALF_W-1:0] WSH_I,
   output logic [rbwe_pkg::HALF_W-1:0] WSH_O,
   output logic W_OE_N_O,
   // Control pins
   input wire logic NARROW_SIDE_ENABLE_FIRST_N_I,
   input wire logic NARROW_SIDE_ENABLE_SECOND_N_I,
   input wire logic WIDE_FIRST_HALF_ENABLE_N_I,
   input wire logic WIDE_SECOND_HALF_ENABLE_N_I,
   input wire logic SEL_I,
   input wire logic NARROW_OUTPUT_ENABLE_N_I,
   input wire logic WIDE_OUTPUT_ENABLE_N_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [rbwe_pkg::APB_AW-1:0] PADDR_I,
   input wire logic [rbwe_pkg::APB_DW-1:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic [rbwe_pkg::APB_DW-1:0] PRDATA_O
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [rbwe_pkg::HALF_W-1:0] pipe_stage;
      logic [rbwe_pkg::HALF_W-1:0] wide_first;
      logic [rbwe_pkg::HALF_W-1:0] wide_second;
      logic [rbwe_pkg::HALF_W-1:0] back_first;
      logic [rbwe_pkg::HALF_W-1:0] back_second;
      logic [rbwe_pkg::NARROW_W-1:0] narrow_out;
      logic sel;
      logic narrow_oe_n;
      logic wide_oe_n;
      logic force_hiz;
      logic pready;
      logic pslverr;
      logic [rbwe_pkg::APB_DW-1:0] prdata;
   } rbwe_state_s;

   localparam rbwe_state_s RST_STATE = '{
      pipe_stage: rbwe_pkg::DATA_RST,
      wide_first: rbwe_pkg::DATA_RST,
      wide_second: rbwe_pkg::DATA_RST,
      back_first: rbwe_pkg::DATA_RST,
      back_second: rbwe_pkg::DATA_RST,
      narrow_out: rbwe_pkg::DATA_RST,
      sel: rbwe_pkg::SEL_RST,
      narrow_oe_n: rbwe_pkg::OE_RST,
      wide_oe_n: rbwe_pkg::OE_RST,
      force_hiz: rbwe_pkg::HIZ_RST,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: rbwe_pkg::RDATA_RST
   };

   rbwe_state_s st;
   rbwe_state_s next_st;

   // Shorter local names for the control pins
   logic na1_n;
   logic na2_n;
   logic wb1_n;
   logic wb2_n;
   assign na1_n = NARROW_SIDE_ENABLE_FIRST_N_I;
   assign na2_n = NARROW_SIDE_ENABLE_SECOND_N_I;
   assign wb1_n = WIDE_FIRST_HALF_ENABLE_N_I;
   assign wb2_n = WIDE_SECOND_HALF_ENABLE_N_I;

   // -----------------------------------------------------------------
   // Register decode
   // -----------------------------------------------------------------
   function automatic logic addr_mapped(input logic [rbwe_pkg::APB_AW-1:0] a);
      addr_mapped = (a == rbwe_pkg::CTRL_OFS) ||
                    (a == rbwe_pkg::STATUS_OFS) ||
                    (a == rbwe_pkg::NARROW_CAP_OFS) ||
                    (a == rbwe_pkg::WIDE_CAP_OFS);
   endfunction : addr_mapped

   function automatic logic [rbwe_pkg::APB_DW-1:0] read_word(
      input logic [rbwe_pkg::APB_AW-1:0] a,
      input rbwe_state_s s
   );
      logic [rbwe_pkg::APB_DW-1:0] w;
      w = rbwe_pkg::RDATA_RST;
      unique case (a)
         rbwe_pkg::CTRL_OFS: begin
            w[rbwe_pkg::CTRL_HIZ_BIT] = s.force_hiz;
         end
         rbwe_pkg::STATUS_OFS: begin
            w[rbwe_pkg::ST_NARROW_OE_BIT] = s.narrow_oe_n;
            w[rbwe_pkg::ST_WIDE_OE_BIT] = s.wide_oe_n;
            w[rbwe_pkg::ST_SEL_BIT] = s.sel;
            w[rbwe_pkg::ST_HIZ_BIT] = s.force_hiz;
         end
         rbwe_pkg::NARROW_CAP_OFS: begin
            w[rbwe_pkg::HALF_W-1:0] = s.pipe_stage;
         end
         rbwe_pkg::WIDE_CAP_OFS: begin
            w[rbwe_pkg::WIDE_W-1:0] = {s.wide_second, s.wide_first};
         end
         default: begin
            w = rbwe_pkg::RDATA_RST;
         end
      endcase
      read_word = w;
   endfunction : read_word

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;

      if (!na1_n && !na2_n) begin
         next_st.pipe_stage = A_I;
         next_st.wide_first = st.pipe_stage;
      end

      if (!na2_n) begin
         next_st.wide_second = A_I;
      end
      // Both narrow enables high leave the branches above idle

      if (!wb1_n && !wb2_n) begin
         next_st.back_first = WFH_I;
      end
      if (!wb2_n) begin
         next_st.back_second = WSH_I;
      end

      next_st.sel = SEL_I;

      // Output register mirrors the mux of the next half registers
      // so the pin comes from a flop with no extra cycle of latency
      next_st.narrow_out = next_st.sel ? next_st.back_first
                                       : next_st.back_second;

      // Registered output enables; software can force both off
      next_st.narrow_oe_n = NARROW_OUTPUT_ENABLE_N_I | st.force_hiz;
      next_st.wide_oe_n = WIDE_OUTPUT_ENABLE_N_I | st.force_hiz;

      // APB: answer one cycle into the access phase
      // Read data is taken from state at the first access edge, so a
      // capture read shows the halves as they stood one cycle earlier
      next_st.pready = 1'b0;
      if (PSEL_I && PENABLE_I && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !addr_mapped(PADDR_I);
         next_st.prdata = PWRITE_I ? rbwe_pkg::RDATA_RST
                                   : read_word(PADDR_I, st);
      end
      // Write lands on the edge that completes the transfer
      if (PSEL_I && PENABLE_I && st.pready) begin
         next_st.pslverr = 1'b0;
         if (PWRITE_I && PSTRB_I[0] && (PADDR_I == rbwe_pkg::CTRL_OFS)) begin
            next_st.force_hiz = PWDATA_I[rbwe_pkg::CTRL_HIZ_BIT];
         end
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // All storage updates on the rising edge only
   // Reset is synchronous: both ports go to high impedance at the first rising edge with reset low
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         st <= RST_STATE;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // 12-bit narrow port, two 12-bit halves on the wide side
   assign A_O = st.narrow_out;
   assign A_OE_N_O = st.narrow_oe_n;
   // Both halves present together as one wide word
   assign WFH_O = st.wide_first;
   assign WSH_O = st.wide_second;
   assign W_OE_N_O = st.wide_oe_n;
   assign PREADY_O = st.pready;
   assign PSLVERR_O = st.pslverr;
   assign PRDATA_O = st.prdata;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // Two edges from narrow input to first half
   a_first_half_pipe: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (!na1_n && !na2_n) ##1 (!na1_n && !na2_n)
      |=> (WFH_O == $past(A_I, 2))
   ) else $error("first half did not get narrow word after two edges");

   // One edge into the second half
   a_second_half_cap: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      !na2_n |=> (WSH_O == $past(A_I))
   ) else $error("second half did not capture narrow word");

   // Hold with both narrow enables high
   a_wide_halves_hold: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (na1_n && na2_n) |=> ($stable(WFH_O) && $stable(WSH_O))
   ) else $error("wide halves changed with narrow enables off");

   a_narrow_sel_first: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (SEL_I && !wb1_n && !wb2_n) |=> (A_O == $past(WFH_I))
   ) else $error("narrow output not first half with select high");

   a_narrow_sel_second: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (!SEL_I && !wb2_n) |=> (A_O == $past(WSH_I))
   ) else $error("narrow output not second half with select low");

   // Selected first half disabled keeps the level
   a_narrow_out_hold: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (SEL_I && wb1_n) ##1 (SEL_I && wb1_n) |=> $stable(A_O)
   ) else $error("narrow output moved while selected half disabled");

   // Narrow enable follows its pin one edge later
   a_narrow_oe_reg: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      ##1 (A_OE_N_O == ($past(NARROW_OUTPUT_ENABLE_N_I) ||
                        $past(st.force_hiz)))
   ) else $error("narrow output enable not registered from pin");

   // Wide enable follows its pin one edge later
   a_wide_oe_reg: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      ##1 (W_OE_N_O == ($past(WIDE_OUTPUT_ENABLE_N_I) ||
                        $past(st.force_hiz)))
   ) else $error("wide output enable not registered from pin");

   // Bus answer comes exactly one cycle into the access phase
   a_apb_answer_time: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O
   ) else $error("APB answer not given after one access cycle");

   // Holds, idle paths, the wide word pair, output enables and the bus handshake;
   // the holds catch a half that loads while its enable is high, which the data checks above miss

   // Selected second half disabled keeps the level
   a_narrow_hold_second: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (!SEL_I && wb2_n) ##1 (!SEL_I && wb2_n) |=> $stable(A_O)
   ) else $error("narrow output moved while second half disabled");

   // First half idles unless both narrow enables are low
   a_first_half_idle: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (na1_n || na2_n) |=> $stable(WFH_O)
   ) else $error("first half changed without both narrow enables");

   // Second half idles while its enable is high
   a_second_half_idle: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      na2_n |=> $stable(WSH_O)
   ) else $error("second half changed with its enable off");

   // Two successive narrow words stand together as one wide word
   a_wide_word_pair: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (!na1_n && !na2_n) ##1 (!na1_n && !na2_n)
      |=> ({WSH_O, WFH_O} == {$past(A_I), $past(A_I, 2)})
   ) else $error("wide word is not the last two narrow words");

   // First back register loads only with both wide enables low
   a_back_first_hold: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (wb1_n || wb2_n) |=> $stable(st.back_first)
   ) else $error("first back register loaded with an enable off");

   // Reset leaves both ports in high impedance
   a_oe_after_reset: assert property (
      @(posedge CLK_I)
      !RST_N_I |=> (A_OE_N_O && W_OE_N_O)
   ) else $error("output enables not inactive after reset");

   // Software high impedance overrides both enable pins
   a_hiz_forces_off: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      st.force_hiz |=> (A_OE_N_O && W_OE_N_O)
   ) else $error("forced high impedance did not disable outputs");

   // Bus answer lasts a single cycle
   a_ready_one_cycle: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      PREADY_O |=> !PREADY_O
   ) else $error("APB ready held for more than one cycle");

   // No answer without a selected transfer
   a_ready_needs_select: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      !PSEL_I |=> !PREADY_O
   ) else $error("APB ready raised without select");

   // Error flag clears at the completing edge
   a_error_cleared: assert property (
      @(posedge CLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && PREADY_O) |=> !PSLVERR_O
   ) else $error("APB error flag not cleared after completion");

endmodule : rbwe_top

// ---- dv/rbwe_bus_model.sv ----
// Far-side bus model feeding the narrow and wide data inputs
module rbwe_bus_model (
   // Drive state of the device
   input wire logic a_oe_n_i,
   input wire logic w_oe_n_i,
   // Data toward the device
   output logic [11:0] a_o,
   output logic [11:0] wfh_o,
   output logic [11:0] wsh_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] a_v = 12'h000;
   logic [11:0] b1_v = 12'h000;
   logic [11:0] b2_v = 12'h000;
   // Released or device-driven bus
   // A bus the device drives shows the inverted model value here, never the last value
   assign a_o = a_oe_n_i ? a_v : ~a_v;
   assign wfh_o = w_oe_n_i ? b1_v : ~b1_v;
   assign wsh_o = w_oe_n_i ? b2_v : ~b2_v;
endmodule : rbwe_bus_model

// ---- dv/rbwe_top_tb.sv ----
// Self-checking bench for the registered bus width exchanger
module rbwe_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic n1_n = 1'b1, n2_n = 1'b1, w1_n = 1'b1, w2_n = 1'b1;
   logic sel = 1'b0, noe_n = 1'b1, woe_n = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, a_oe_n, w_oe_n;
   logic [31:0] prdata;
   logic [11:0] a_i, wfh_i, wsh_i, a_o, wfh_o, wsh_o;
   int n_mismatch = 0;
   int total_checks = 0;
   always #20 clk = ~clk;
   rbwe_bus_model i_bus (.a_oe_n_i(a_oe_n), .w_oe_n_i(w_oe_n),
      .a_o(a_i), .wfh_o(wfh_i), .wsh_o(wsh_i));
   rbwe_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .A_I(a_i), .A_O(a_o),
      .A_OE_N_O(a_oe_n), .WFH_I(wfh_i), .WFH_O(wfh_o), .WSH_I(wsh_i),
      .WSH_O(wsh_o), .W_OE_N_O(w_oe_n), .NARROW_SIDE_ENABLE_FIRST_N_I(n1_n),
      .NARROW_SIDE_ENABLE_SECOND_N_I(n2_n), .WIDE_FIRST_HALF_ENABLE_N_I(w1_n),
      .WIDE_SECOND_HALF_ENABLE_N_I(w2_n), .SEL_I(sel),
      .NARROW_OUTPUT_ENABLE_N_I(noe_n), .WIDE_OUTPUT_ENABLE_N_I(woe_n),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .PRDATA_O(prdata));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Control word is {n1,n2,w1,w2,sel,noe,woe}, all set at one edge
   task automatic cyc(input logic [11:0] a, b1, b2, input logic [6:0] c);
      @(posedge clk);
      i_bus.a_v <= a;
      i_bus.b1_v <= b1;
      i_bus.b2_v <= b2;
      {n1_n, n2_n, w1_n, w2_n, sel, noe_n, woe_n} <= c;
   endtask : cyc
   task automatic apb(input logic wr, input logic [7:0] ad,
         input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1, "apb hang");
   endtask : apb
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      logic [31:0] rd;
      logic er;
      // Enables held high while clocking from the start
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({a_oe_n, w_oe_n}, 2'b11, "oe after reset");
      for (int i = 0; i < 5; i++) begin
         cyc(12'h000, 12'h000, 12'h000, {5'h1E, 2'(i) ^ 2'b10});
         @(negedge clk);
         if (i > 0) chk({a_oe_n, w_oe_n}, 2'(i - 1) ^ 2'b10, "oe");
      end
      cyc(12'hA51, 12'h000, 12'h000, 7'h1A);
      cyc(12'h3C7, 12'h000, 12'h000, 7'h1A);
      @(negedge clk);
      chk({wfh_o, wsh_o}, {12'h000, 12'hA51}, "one edge");
      cyc(12'hFFF, 12'h000, 12'h000, 7'h7A);
      @(negedge clk);
      chk({wsh_o, wfh_o}, {12'h3C7, 12'hA51}, "wide pair");
      cyc(12'h0E2, 12'h000, 12'h000, 7'h5A);
      @(negedge clk);
      chk({wsh_o, wfh_o}, {12'h3C7, 12'hA51}, "hold");
      cyc(12'h0E2, 12'h000, 12'h000, 7'h79);
      @(negedge clk);
      chk({wsh_o, wfh_o}, {12'h0E2, 12'hA51}, "second only");
      cyc(12'h000, 12'h000, 12'h000, 7'h79);
      cyc(12'h000, 12'h5B4, 12'h96D, 7'h65);
      cyc(12'h000, 12'h111, 12'h2C8, 7'h71);
      @(negedge clk);
      chk(a_o, 12'h5B4, "first half");
      cyc(12'h000, 12'h7F0, 12'h803, 7'h6D);
      @(negedge clk);
      chk(a_o, 12'h2C8, "second half");
      cyc(12'h000, 12'h7F0, 12'h803, 7'h69);
      @(negedge clk);
      chk(a_o, 12'h5B4, "first needs both");
      cyc(12'h000, 12'h7F0, 12'h803, 7'h79);
      @(negedge clk);
      chk(a_o, 12'h2C8, "second held");
      chk({wsh_o, wfh_o}, {12'h0E2, 12'hA51}, "wide kept");
      cyc(12'h000, 12'h0AA, 12'h0BB, 7'h7D);
      cyc(12'h000, 12'h0AA, 12'h0BB, 7'h7D);
      @(negedge clk);
      chk(a_o, 12'h5B4, "first held");
      cyc(12'h000, 12'h0AA, 12'h0BB, 7'h79);
      apb(1'b0, rbwe_pkg::WIDE_CAP_OFS, 32'h0, rd, er);
      chk(rd, 32'h0E2A51, "wide capture");
      apb(1'b0, rbwe_pkg::NARROW_CAP_OFS, 32'h0, rd, er);
      chk(rd, 32'h3C7, "stage one");
      apb(1'b0, rbwe_pkg::STATUS_OFS, 32'h0, rd, er);
      chk(rd, 32'h2, "status");
      chk(32'(er), 32'h0, "status error");
      apb(1'b1, rbwe_pkg::CTRL_OFS, 32'h1, rd, er);
      apb(1'b0, rbwe_pkg::STATUS_OFS, 32'h0, rd, er);
      chk(rd, 32'hB, "forced off");
      apb(1'b0, rbwe_pkg::CTRL_OFS, 32'h0, rd, er);
      chk(rd, 32'h1, "ctrl readback");
      apb(1'b1, 8'h10, 32'h1, rd, er);
      chk(rd, 32'h0, "unmapped data");
      chk(32'(er), 32'h1, "unmapped error");
      wrap_up();
   end
endmodule : rbwe_top_tb
